// *** lssr_map.svh ***
`ifndef LSSR_MAP_SVH
`define LSSR_MAP_SVH
// =====================================================================
// register indexes (control registers)
`define LSSR_IDX_ERR_EN 4'h0
`define LSSR_IDX_BUF_EN 4'h1
`define LSSR_IDX_LINE_EN 4'h2
// =====================================================================
// read-back upper nibble and power-up defaults
`define LSSR_CTRL_UPPER 4'h4
`define LSSR_ERR_EN_RST 4'h0
`define LSSR_BUF_EN_RST 4'h0
`define LSSR_LINE_EN_RST 4'h0
// =====================================================================
// enable field positions, and the request bit of the system status byte
`define LSSR_MASTER_BIT 3
`define LSSR_ERR_BIT 2
`define LSSR_LOST_BIT 0
`define LSSR_DISC_BIT 1
`define LSSR_BRK_BIT 0
`define LSSR_SRQ_BIT 6
// =====================================================================
// system status codes, request flag clear
`define LSSR_CODE_DEVICE 8'h8a
`define LSSR_CODE_DATA_ERR 8'h83
`define LSSR_CODE_RDY_SEND 8'ha2
`define LSSR_CODE_RDY_RECV 8'ha1
`define LSSR_CODE_NOT_RDY 8'ha3
// =====================================================================
// status record length
`define LSSR_STATUS_BYTES 4
`endif

// *** lssr_pkg.sv ***
package lssr_pkg;
  // live conditions from the serial side
  typedef struct packed {
    logic rx_full;
    logic rx_not_empty;
    logic tx_not_full;
    logic tx_not_empty;
    logic remote_mode;
    logic sw_hs_block;
    logic hw_hs_block;
    logic cts_no_resp;
  } lssr_levels_t;
  // one-cycle event pulses from the serial side
  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic overrun;
    logic rx_overflow;
    logic break_rx;
    logic syntax_err;
  } lssr_events_t;
  // loop frame passing through
  typedef enum logic [1:0] {
    LSSR_FR_DATA,
    LSSR_FR_END,
    LSSR_FR_IDY,
    LSSR_FR_OTHER
  } lssr_frame_kind_t;
  typedef struct packed {
    lssr_frame_kind_t kind;
    logic srq;
    logic [7:0] data;
  } lssr_frame_t;
endpackage : lssr_pkg

// *** lssr_prio_enc.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lssr_map.svh"
// =====================================================================
// system status byte priority encoder
module lssr_prio_enc (
  // conditions
  input wire logic device_cond_i,
  input wire logic data_err_i,
  input wire logic rx_data_i,
  input wire logic tx_not_full_i,
  input wire logic srq_i,
  // code
  output logic [7:0] code_o
);
  logic [7:0] base;
  // highest active condition only
  always_comb begin
    if (device_cond_i) begin
      base = `LSSR_CODE_DEVICE;
    end else if (data_err_i) begin
      base = `LSSR_CODE_DATA_ERR;
    end else if (rx_data_i) begin
      base = `LSSR_CODE_RDY_SEND;
    end else if (tx_not_full_i) begin
      base = `LSSR_CODE_RDY_RECV;
    end else begin
      base = `LSSR_CODE_NOT_RDY;
    end
    code_o = base;
    code_o[`LSSR_SRQ_BIT] = srq_i;
  end
endmodule : lssr_prio_enc
`default_nettype wire

// *** lssr_srq_frame.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lssr_map.svh"
// =====================================================================
// marks passing data, end and identify frames as service requests
module lssr_srq_frame (
  // frame in
  input wire lssr_pkg::lssr_frame_t frame_i,
  input wire logic srq_i,
  // frame out
  output lssr_pkg::lssr_frame_t frame_o
);
  import lssr_pkg::*;
  // other frame kinds pass untouched
  always_comb begin
    frame_o = frame_i;
    if (srq_i && frame_i.kind != LSSR_FR_OTHER) begin
      frame_o.srq = 1'b1;
    end
  end
endmodule : lssr_srq_frame
`default_nettype wire

// *** loop_status_service_request.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lssr_map.svh"
// =====================================================================
// status record and service request logic
module loop_status_service_request (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // serial side conditions
  input wire lssr_pkg::lssr_levels_t levels_i,
  input wire lssr_pkg::lssr_events_t events_i,
  input wire logic rx_frame_bad_i,
  // control register access from the loop
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_idx_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // status request: start and byte pull
  input wire logic status_req_i,
  input wire logic status_next_i,
  output logic [7:0] status_byte_o,
  output logic status_valid_o,
  output logic status_eot_o,
  // loop frame forwarding
  input wire lssr_pkg::lssr_frame_t frame_i,
  output lssr_pkg::lssr_frame_t frame_o,
  // state out
  output logic srq_o,
  output logic auto_disc_o,
  output logic rx_frame_drop_o
);
  import lssr_pkg::*;

  // =====================================================================
  // control registers
  logic [3:0] err_en_q, err_en_d;
  logic [3:0] buf_en_q, buf_en_d;
  logic [3:0] line_en_q, line_en_d;
  logic [7:0] rdata_q, rdata_d;

  // writes keep the low nibble only
  always_comb begin
    err_en_d = err_en_q;
    buf_en_d = buf_en_q;
    line_en_d = line_en_q;
    rdata_d = rdata_q;
    if (reg_wr_i) begin
      unique case (reg_idx_i)
        `LSSR_IDX_ERR_EN: err_en_d = reg_wdata_i[3:0];
        `LSSR_IDX_BUF_EN: buf_en_d = reg_wdata_i[3:0];
        `LSSR_IDX_LINE_EN: line_en_d = reg_wdata_i[3:0];
        default: ;
      endcase
    end
    // read answers one cycle later, upper nibble fixed for printable text
    if (reg_rd_i) begin
      unique case (reg_idx_i)
        `LSSR_IDX_ERR_EN: rdata_d = {`LSSR_CTRL_UPPER, err_en_q};
        `LSSR_IDX_BUF_EN: rdata_d = {`LSSR_CTRL_UPPER, buf_en_q};
        `LSSR_IDX_LINE_EN: rdata_d = {`LSSR_CTRL_UPPER, line_en_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // power-up defaults
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      err_en_q <= `LSSR_ERR_EN_RST;
      buf_en_q <= `LSSR_BUF_EN_RST;
      line_en_q <= `LSSR_LINE_EN_RST;
      rdata_q <= 8'h00;
    end else begin
      err_en_q <= err_en_d;
      buf_en_q <= buf_en_d;
      line_en_q <= line_en_d;
      rdata_q <= rdata_d;
    end
  end

  // =====================================================================
  // latched flags, and the one-cycle registered frame drop pulse
  logic par_q, par_d;
  logic frm_q, frm_d;
  logic ovr_q, ovr_d;
  logic ovf_q, ovf_d;
  logic brk_q, brk_d;
  logic syn_q, syn_d;
  logic disc_q, disc_d;
  logic drop_q, drop_d;
  logic sent_clr;

  // set beats the post-status clear in the same cycle
  always_comb begin
    par_d = events_i.parity_err | (par_q & ~sent_clr);
    frm_d = events_i.frame_err | (frm_q & ~sent_clr);
    ovr_d = events_i.overrun | (ovr_q & ~sent_clr);
    ovf_d = events_i.rx_overflow | (ovf_q & ~sent_clr);
    brk_d = events_i.break_rx | (brk_q & ~sent_clr);
    syn_d = events_i.syntax_err | (syn_q & ~sent_clr);
    // disconnect holds until reset; the serial side has no resume here
    disc_d = disc_q | events_i.rx_overflow;
    drop_d = rx_frame_bad_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      par_q <= 1'b0;
      frm_q <= 1'b0;
      ovr_q <= 1'b0;
      ovf_q <= 1'b0;
      brk_q <= 1'b0;
      syn_q <= 1'b0;
      disc_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      par_q <= par_d;
      frm_q <= frm_d;
      ovr_q <= ovr_d;
      ovf_q <= ovf_d;
      brk_q <= brk_d;
      syn_q <= syn_d;
      disc_q <= disc_d;
      drop_q <= drop_d;
    end
  end

  // =====================================================================
  // service request
  logic cause_err, cause_buf, cause_line, cause_any;
  logic srq_q, srq_d;
  logic srq_hold_q, srq_hold_d;

  // each cause only counts when its enable is set
  assign cause_err = (err_en_q[`LSSR_ERR_BIT] &
                      (par_q | frm_q | ovr_q | ovf_q)) |
                     (err_en_q[`LSSR_LOST_BIT] & ovf_q);
  assign cause_buf = |(buf_en_q & {levels_i.rx_full,
                                   levels_i.rx_not_empty,
                                   levels_i.tx_not_full,
                                   ~levels_i.tx_not_empty});
  assign cause_line = (line_en_q[`LSSR_DISC_BIT] & disc_q) |
                      (line_en_q[`LSSR_BRK_BIT] & brk_q);
  assign cause_any = err_en_q[`LSSR_MASTER_BIT] &
                     (cause_err | cause_buf | cause_line);

  // a sent status suppresses the flag until the cause drops once
  always_comb begin
    srq_hold_d = srq_hold_q;
    if (sent_clr) begin
      srq_hold_d = 1'b1;
    end else if (!cause_any) begin
      srq_hold_d = 1'b0;
    end
    srq_d = cause_any & ~srq_hold_d;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      srq_q <= 1'b0;
      srq_hold_q <= 1'b0;
    end else begin
      srq_q <= srq_d;
      srq_hold_q <= srq_hold_d;
    end
  end

  // =====================================================================
  // status record
  logic [7:0] sys_code;
  logic [7:0] rec [`LSSR_STATUS_BYTES];

  lssr_prio_enc u_prio (
    .device_cond_i(disc_q | brk_q),
    .data_err_i(par_q | frm_q | ovf_q),
    .rx_data_i(levels_i.rx_not_empty),
    .tx_not_full_i(levels_i.tx_not_full),
    .srq_i(srq_q),
    .code_o(sys_code)
  );

  // bytes follow live state every cycle
  always_comb begin
    rec[0] = sys_code;
    rec[1] = {par_q, frm_q, ovr_q, ovf_q,
              levels_i.rx_full, levels_i.rx_not_empty,
              levels_i.tx_not_full, levels_i.tx_not_empty};
    rec[2] = {levels_i.cts_no_resp, 1'b0, disc_q, brk_q,
              levels_i.remote_mode, syn_q,
              levels_i.sw_hs_block, levels_i.hw_hs_block};
    rec[3] = 8'h00;
  end

  // =====================================================================
  // status send sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND,
    ST_EOT
  } lssr_state_t;
  lssr_state_t st_q, st_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] sbyte_q, sbyte_d;
  logic sval_q, sval_d;
  logic eot_q, eot_d;

  // a new request is ignored while an answer is in progress
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    sbyte_d = sbyte_q;
    sval_d = 1'b0;
    eot_d = 1'b0;
    sent_clr = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (status_req_i) begin
          st_d = ST_SEND;
          idx_d = 2'd0;
          sbyte_d = rec[0];
          sval_d = 1'b1;
        end
      end
      ST_SEND: begin
        sval_d = 1'b1;
        if (status_next_i) begin
          if (idx_q == 2'd3) begin
            st_d = ST_EOT;
            sval_d = 1'b0;
          end else begin
            idx_d = idx_q + 2'd1;
            sbyte_d = rec[idx_q + 2'd1];
          end
        end
      end
      ST_EOT: begin
        eot_d = 1'b1;
        sent_clr = 1'b1;
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      idx_q <= 2'd0;
      sbyte_q <= 8'h00;
      sval_q <= 1'b0;
      eot_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      sbyte_q <= sbyte_d;
      sval_q <= sval_d;
      eot_q <= eot_d;
    end
  end

  // =====================================================================
  // loop frame forwarding
  lssr_frame_t fwd_d, fwd_q;

  lssr_srq_frame u_frame (
    .frame_i(frame_i),
    .srq_i(srq_q),
    .frame_o(fwd_d)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fwd_q <= '0;
    end else begin
      fwd_q <= fwd_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o = rdata_q;
  assign status_byte_o = sbyte_q;
  assign status_valid_o = sval_q;
  assign status_eot_o = eot_q;
  assign frame_o = fwd_q;
  assign srq_o = srq_q;
  assign auto_disc_o = disc_q;
  assign rx_frame_drop_o = drop_q;
endmodule : loop_status_service_request
`default_nettype wire

// *** lssr_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// port-level checks of the status and request block
module lssr_asserts (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire lssr_pkg::lssr_events_t events_i,
  input wire logic rx_frame_bad_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_idx_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic status_next_i,
  input wire logic [7:0] status_byte_o,
  input wire logic status_valid_o,
  input wire logic status_eot_o,
  input wire lssr_pkg::lssr_frame_t frame_i,
  input wire lssr_pkg::lssr_frame_t frame_o,
  input wire logic srq_o,
  input wire logic auto_disc_o,
  input wire logic rx_frame_drop_o
);
  import lssr_pkg::*;
  logic [2:0] cnt_q, cnt_d;
  logic mst_q, mst_d;
  // bytes pulled in this answer, and a copy of the master enable
  always_comb begin
    cnt_d = cnt_q;
    mst_d = mst_q;
    if (status_eot_o) cnt_d = 3'h0;
    else if (status_valid_o && status_next_i) cnt_d = cnt_q + 3'h1;
    if (reg_wr_i && reg_idx_i == 4'h0) mst_d = reg_wdata_i[3];
  end
  always_ff @(posedge sys_clk_i) begin
    cnt_q <= rst_n_i ? cnt_d : 3'h0;
    mst_q <= rst_n_i ? mst_d : 1'b0;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // =====================================================================
  // assertions
  ctrl_upper_a: assert property (
    reg_rd_i && reg_idx_i < 4'h3 |=> reg_rdata_o[7:4] == 4'h4)
    else $error("control read upper nibble wrong");
  unmapped_read_a: assert property (
    reg_rd_i && reg_idx_i > 4'h2 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  sys_code_a: assert property (
    status_valid_o && cnt_q == 3'h0 |-> status_byte_o[7] &&
    status_byte_o[5:0] inside {6'h0a, 6'h03, 6'h22, 6'h21, 6'h23})
    else $error("system byte not a legal code");
  line_bit6_a: assert property (
    status_valid_o && cnt_q == 3'h2 |-> !status_byte_o[6])
    else $error("line byte bit 6 set");
  spare_zero_a: assert property (
    status_valid_o && cnt_q == 3'h3 |-> status_byte_o == 8'h00)
    else $error("spare byte not zero");
  // valid drops a cycle before the end pulse rises
  four_bytes_a: assert property (
    $rose(status_eot_o) |-> cnt_q == 3'h4 && !status_valid_o &&
    $past(status_valid_o, 2) ##1 !status_eot_o)
    else $error("answer not four bytes then end");
  master_gate_a: assert property (
    !mst_q && !$past(mst_q) |-> !srq_o)
    else $error("request without master enable");
  frame_mark_a: assert property (
    frame_i.kind != LSSR_FR_OTHER && srq_o |=> frame_o.srq)
    else $error("passing frame not marked");
  frame_pass_a: assert property (
    1'b1 |=> frame_o.data == $past(frame_i.data) &&
    frame_o.kind == $past(frame_i.kind))
    else $error("forwarded frame altered");
  disc_sticky_a: assert property (
    events_i.rx_overflow || auto_disc_o |=> auto_disc_o)
    else $error("auto disconnect not held");
  drop_follow_a: assert property (
    rx_frame_bad_i |=> rx_frame_drop_o ##1 !rx_frame_drop_o)
    else $error("bad frame not discarded");
  // main scenarios reached
  cv_eot: cover property (status_eot_o);
  cv_mark: cover property (srq_o && frame_i.kind == LSSR_FR_DATA);
  cv_disc: cover property (auto_disc_o);
endmodule : lssr_asserts
bind loop_status_service_request lssr_asserts u_asserts (.sys_clk_i,
  .rst_n_i, .events_i, .rx_frame_bad_i, .reg_wr_i, .reg_rd_i,
  .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .status_next_i,
  .status_byte_o, .status_valid_o, .status_eot_o, .frame_i, .frame_o,
  .srq_o, .auto_disc_o, .rx_frame_drop_o);
`default_nettype wire

// *** lssr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// host loop controller: sets registers and pulls status
module lssr_host_model (
  // clock
  input wire logic sys_clk_i,
  // register access
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [3:0] reg_idx_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  // status answer
  output logic status_req_o,
  output logic status_next_o,
  input wire logic [7:0] status_byte_i
);
  // idle at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_idx_o = 4'h0;
    reg_wdata_o = 8'h00;
    status_req_o = 1'b0;
    status_next_o = 1'b0;
  end
  // released fields show the inverse so stale values never look valid
  task automatic wr_reg(input logic [3:0] idx, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b1;
    reg_idx_o <= idx;
    reg_wdata_o <= d;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_idx_o <= ~idx;
    reg_wdata_o <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] idx, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b1;
    reg_idx_o <= idx;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_idx_o <= ~idx;
    #1 d = reg_rdata_i;
  endtask : rd_reg
  // gap stalls before each pull, as a slow controller would
  task automatic get_status(input int gap, output logic [31:0] rec);
    @(posedge sys_clk_i);
    status_req_o <= 1'b1;
    @(posedge sys_clk_i);
    status_req_o <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      repeat (gap) @(posedge sys_clk_i);
      #1 rec = {rec[23:0], status_byte_i};
      @(posedge sys_clk_i);
      status_next_o <= 1'b1;
      @(posedge sys_clk_i);
      status_next_o <= 1'b0;
    end
    @(posedge sys_clk_i);
  endtask : get_status
endmodule : lssr_host_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// status record and request tests
module testbench;
  import lssr_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  lssr_levels_t levels_i = '0;
  lssr_events_t events_i = '0;
  logic rx_frame_bad_i = 1'b0;
  lssr_frame_t frame_i = '0;
  lssr_frame_t frame_o;
  logic reg_wr_i, reg_rd_i, status_req_i, status_next_i;
  logic [3:0] reg_idx_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, status_byte_o, rd;
  logic status_valid_o, status_eot_o, srq_o, auto_disc_o;
  logic rx_frame_drop_o;
  logic [31:0] rec;
  int errors = 0;
  int compares = 0;
  logic [7:0] lv_tab [4] = '{8'h20, 8'h70, 8'h0f, 8'hc0};
  logic [31:0] st_tab [4] = '{32'ha1020000, 32'ha2070000,
    32'ha3008b00, 32'ha20c0000};
  logic [5:0] ev_tab [5] = '{6'h20, 6'h10, 6'h08, 6'h01, 6'h02};
  logic [31:0] ev_exp [5] = '{32'h83820000, 32'h83420000,
    32'ha1220000, 32'ha1020400, 32'h8a021000};
  always #5 sys_clk_i = ~sys_clk_i;
  loop_status_service_request u_dut (.sys_clk_i, .rst_n_i, .levels_i,
    .events_i, .rx_frame_bad_i, .reg_wr_i, .reg_rd_i, .reg_idx_i,
    .reg_wdata_i, .reg_rdata_o, .status_req_i, .status_next_i,
    .status_byte_o, .status_valid_o, .status_eot_o, .frame_i, .frame_o,
    .srq_o, .auto_disc_o, .rx_frame_drop_o);
  lssr_host_model u_host (.sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_idx_o(reg_idx_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .status_req_o(status_req_i), .status_next_o(status_next_i),
    .status_byte_i(status_byte_o));
  // =====================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [5:0] ev, input logic bad);
    @(posedge sys_clk_i);
    events_i <= ev;
    rx_frame_bad_i <= bad;
    @(posedge sys_clk_i);
    events_i <= '0;
    rx_frame_bad_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask : pulse
  // flag lags its cause by a cycle, so allow three
  task automatic srq_is(input logic e);
    repeat (3) @(posedge sys_clk_i);
    #1 chk({31'h0, srq_o}, {31'h0, e});
  endtask : srq_is
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // =====================================================================
  // tests
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_host.rd_reg(i[3:0], rd);
      chk({24'h0, rd}, (i < 3) ? 32'h40 : 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      u_host.wr_reg(i[3:0], 8'hb5);
      u_host.rd_reg(i[3:0], rd);
      chk({24'h0, rd}, 32'h45);
      u_host.wr_reg(i[3:0], 8'h00);
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      levels_i <= lv_tab[i];
      u_host.get_status(i, rec);
      chk(rec, st_tab[i]);
    end
    $display("test levels done");
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk_i);
      levels_i <= 8'h20;
      pulse(ev_tab[i], i == 1);
      u_host.get_status(0, rec);
      chk(rec, ev_exp[i]);
      u_host.get_status(0, rec);
      chk(rec, 32'ha1020000);
    end
    $display("test events done");
    u_host.wr_reg(4'h0, 8'hf8);
    u_host.wr_reg(4'h1, 8'h02);
    srq_is(1'b1);
    @(posedge sys_clk_i);
    frame_i <= '{LSSR_FR_DATA, 1'b0, 8'h5a};
    @(posedge sys_clk_i);
    frame_i <= '{LSSR_FR_OTHER, 1'b0, 8'h3c};
    #1 chk({21'h0, frame_o}, {21'h0, LSSR_FR_DATA, 9'h15a});
    @(posedge sys_clk_i);
    #1 chk({21'h0, frame_o}, {21'h0, LSSR_FR_OTHER, 9'h03c});
    u_host.get_status(0, rec);
    chk(rec, 32'he1020000);
    srq_is(1'b0);
    levels_i <= 8'h00;
    srq_is(1'b0);
    levels_i <= 8'h20;
    srq_is(1'b1);
    u_host.wr_reg(4'h0, 8'h00);
    srq_is(1'b0);
    $display("test request done");
    u_host.wr_reg(4'h1, 8'h00);
    u_host.wr_reg(4'h2, 8'h01);
    u_host.wr_reg(4'h0, 8'h08);
    pulse(6'h02, 1'b0);
    srq_is(1'b1);
    u_host.get_status(0, rec);
    chk(rec, 32'hca021000);
    u_host.wr_reg(4'h2, 8'h02);
    pulse(6'h04, 1'b0);
    chk({31'h0, auto_disc_o}, 32'h1);
    u_host.get_status(0, rec);
    chk(rec, 32'hca122000);
    u_host.get_status(0, rec);
    chk(rec, 32'h8a022000);
    $display("test line events done");
    report_and_stop();
  end
  // watchdog, well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
